// ---- ratl_bank.v ----
// Notes on behaviour
// - read-to-clear field clears after read
// - read/write field stores and returns written value
// - write one clears bit, zero leaves it
// - writing back read status clears only those
// - write one sets bit, zero no change
// - write-only clear; read data meaningless
// - write-only register; reads carry no meaning
// - reserved bits read as zero
// - address is base plus register offset
`timescale 1ns/1ps
`include "ratl_defs.vh"
module ratl_bank #(
   parameter [31:0] BASE_ADDR = 32'h40000000,
   parameter [31:0] RSV_MASK  = 32'h00000000
) (
   input  wire        clk_i,
   input  wire        rst_n_i,
   input  wire        sel_i,
   input  wire        wr_i,
   input  wire [31:0] addr_i,
   input  wire [31:0] wdata_i,
   input  wire [31:0] ro_val_i,
   input  wire [31:0] rc_set_i,
   input  wire [31:0] st_set_i,
   input  wire [31:0] w1c_set_i,
   output reg  [31:0] rdata_o,
   output reg         ack_o,
   output reg         err_o,
   output reg  [31:0] ctrl_o,
   output reg  [31:0] set_o,
   output reg  [31:0] wo_o,
   output reg  [31:0] w1c_o
);
   localparam [31:0] KEEP = ~RSV_MASK;
   reg         rs1_q;
   reg         rs2_q;
   wire        rst_n;
   wire [31:0] ofs;
   wire        hit;
   wire        rd;
   wire        wr;
   wire [31:0] v_rw;
   wire [31:0] v_rc;
   wire [31:0] v_st;
   wire [31:0] v_set;
   wire [31:0] v_w1c;
   wire [31:0] v_wo;
   wire [31:0] r_rw;
   wire [31:0] r_ro;
   wire [31:0] r_rc;
   wire [31:0] r_st;
   wire [31:0] r_set;
   wire [31:0] r_w1c;
   wire [31:0] r_wo;
   reg  [31:0] rd_d;
   reg         known;
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rs1_q <= 1'b0;
         rs2_q <= 1'b0;
      end else begin
         rs1_q <= 1'b1;
         rs2_q <= rs1_q;
      end
   end
   assign rst_n = rs2_q;
   function is_reg;
      input [31:0] o;
      input [11:0] r;
      begin
         is_reg = (o == {20'h00000, r});
      end
   endfunction
   assign ofs = addr_i - BASE_ADDR;
   assign hit = sel_i && (ofs[31:`RATL_OFS_W] == 20'h00000);
   assign rd = sel_i && !wr_i;
   assign wr = sel_i && wr_i;
   ratl_field #(
      .ACCESS (`RATL_AT_RW),
      .RESET  (`RATL_RST_RW),
      .MASK   (KEEP)
   ) u_rw (
      .clk_i    (clk_i),
      .rst_n_i  (rst_n),
      .wr_i     (wr && is_reg(ofs, `RATL_OFS_RW)),
      .rd_i     (1'b0),
      .wdata_i  (wdata_i),
      .hw_set_i (32'h00000000),
      .hw_val_i (32'h00000000),
      .value_o  (v_rw),
      .rdata_o  (r_rw)
   );
   // live hardware value; bus writes land nowhere
   ratl_field #(
      .ACCESS (`RATL_AT_RO),
      .RESET  (`RATL_RST_STAT),
      .MASK   (KEEP)
   ) u_ro (
      .clk_i    (clk_i),
      .rst_n_i  (rst_n),
      .wr_i     (wr && is_reg(ofs, `RATL_OFS_RO)),
      .rd_i     (1'b0),
      .wdata_i  (wdata_i),
      .hw_set_i (32'h00000000),
      .hw_val_i (ro_val_i),
      .value_o  (),
      .rdata_o  (r_ro)
   );
   // cleared by the read strobe itself, no write path
   ratl_field #(
      .ACCESS (`RATL_AT_RC),
      .RESET  (`RATL_RST_STAT),
      .MASK   (KEEP)
   ) u_rc (
      .clk_i    (clk_i),
      .rst_n_i  (rst_n),
      .wr_i     (1'b0),
      .rd_i     (rd && is_reg(ofs, `RATL_OFS_RC)),
      .wdata_i  (wdata_i),
      .hw_set_i (rc_set_i),
      .hw_val_i (32'h00000000),
      .value_o  (v_rc),
      .rdata_o  (r_rc)
   );
   ratl_field #(
      .ACCESS (`RATL_AT_RW1C),
      .RESET  (`RATL_RST_STAT),
      .MASK   (KEEP)
   ) u_st (
      .clk_i    (clk_i),
      .rst_n_i  (rst_n),
      .wr_i     (wr && is_reg(ofs, `RATL_OFS_RW1C)),
      .rd_i     (1'b0),
      .wdata_i  (wdata_i),
      .hw_set_i (st_set_i),
      .hw_val_i (32'h00000000),
      .value_o  (v_st),
      .rdata_o  (r_st)
   );
   ratl_field #(
      .ACCESS (`RATL_AT_RW1S),
      .RESET  (`RATL_RST_RW1S),
      .MASK   (KEEP)
   ) u_set (
      .clk_i    (clk_i),
      .rst_n_i  (rst_n),
      .wr_i     (wr && is_reg(ofs, `RATL_OFS_RW1S)),
      .rd_i     (1'b0),
      .wdata_i  (wdata_i),
      .hw_set_i (32'h00000000),
      .hw_val_i (32'h00000000),
      .value_o  (v_set),
      .rdata_o  (r_set)
   );
   // write-only clear; its read path always gives zero
   ratl_field #(
      .ACCESS (`RATL_AT_W1C),
      .RESET  (`RATL_RST_STAT),
      .MASK   (KEEP)
   ) u_w1c (
      .clk_i    (clk_i),
      .rst_n_i  (rst_n),
      .wr_i     (wr && is_reg(ofs, `RATL_OFS_W1C)),
      .rd_i     (1'b0),
      .wdata_i  (wdata_i),
      .hw_set_i (w1c_set_i),
      .hw_val_i (32'h00000000),
      .value_o  (v_w1c),
      .rdata_o  (r_w1c)
   );
   ratl_field #(
      .ACCESS (`RATL_AT_WO),
      .RESET  (`RATL_RST_WO),
      .MASK   (KEEP)
   ) u_wo (
      .clk_i    (clk_i),
      .rst_n_i  (rst_n),
      .wr_i     (wr && is_reg(ofs, `RATL_OFS_WO)),
      .rd_i     (1'b0),
      .wdata_i  (wdata_i),
      .hw_set_i (32'h00000000),
      .hw_val_i (32'h00000000),
      .value_o  (v_wo),
      .rdata_o  (r_wo)
   );
   always @* begin
      rd_d  = 32'h00000000;
      known = 1'b1;
      case (ofs[`RATL_OFS_W-1:0])
         `RATL_OFS_RW:   rd_d = r_rw;
         `RATL_OFS_RO:   rd_d = r_ro;
         `RATL_OFS_RC:   rd_d = r_rc;
         `RATL_OFS_RW1C: rd_d = r_st;
         `RATL_OFS_RW1S: rd_d = r_set;
         `RATL_OFS_W1C:  rd_d = r_w1c;
         `RATL_OFS_WO:   rd_d = r_wo;
         default:        known = 1'b0;
      endcase
      if (!hit) known = 1'b0;
   end
   always @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         rdata_o <= 32'h00000000;
         ack_o   <= 1'b0;
         err_o   <= 1'b0;
         ctrl_o  <= `RATL_RST_RW;
         set_o   <= `RATL_RST_RW1S;
         wo_o    <= `RATL_RST_WO;
         w1c_o   <= `RATL_RST_STAT;
      end else begin
         rdata_o <= (rd && known) ? rd_d : 32'h00000000;
         ack_o   <= sel_i;
         err_o   <= sel_i && !known;
         ctrl_o  <= v_rw;
         set_o   <= v_set;
         wo_o    <= v_wo;
         w1c_o   <= v_w1c | v_st | v_rc;
      end
   end
endmodule

// ---- ratl_defs.vh ----
`ifndef RATL_DEFS_VH
`define RATL_DEFS_VH
// field access types, one 3-bit code per field
`define RATL_AT_RSV   3'h0
`define RATL_AT_RO    3'h1
`define RATL_AT_RW    3'h2
`define RATL_AT_RC    3'h3
`define RATL_AT_RW1C  3'h4
`define RATL_AT_RW1S  3'h5
`define RATL_AT_W1C   3'h6
`define RATL_AT_WO    3'h7
`define RATL_AT_W     3
// register offsets, relative to the module base
`define RATL_OFS_RW   12'h000
`define RATL_OFS_RO   12'h004
`define RATL_OFS_RC   12'h008
`define RATL_OFS_RW1C 12'h00c
`define RATL_OFS_RW1S 12'h010
`define RATL_OFS_W1C  12'h014
`define RATL_OFS_WO   12'h018
`define RATL_OFS_W    12
`define RATL_NUM_REGS 7
// reset values
`define RATL_RST_RW   32'h00000000
`define RATL_RST_RW1S 32'h00000000
`define RATL_RST_WO   32'h00000000
`define RATL_RST_STAT 32'h00000000
`endif

// ---- ratl_field.v ----
`timescale 1ns/1ps
`include "ratl_defs.vh"
module ratl_field #(
   parameter [2:0]  ACCESS = `RATL_AT_RW,
   parameter [31:0] RESET  = 32'h00000000,
   parameter [31:0] MASK   = 32'hffffffff
) (
   input  wire        clk_i,
   input  wire        rst_n_i,
   input  wire        wr_i,
   input  wire        rd_i,
   input  wire [31:0] wdata_i,
   input  wire [31:0] hw_set_i,
   input  wire [31:0] hw_val_i,
   output wire [31:0] value_o,
   output wire [31:0] rdata_o
);
   reg  [31:0] val_q;
   reg  [31:0] val_d;
   always @* begin
      val_d = val_q;
      case (ACCESS)
         `RATL_AT_RW, `RATL_AT_WO: begin
            if (wr_i) val_d = wdata_i;
         end
         `RATL_AT_RO: begin
            val_d = hw_val_i;
         end
         `RATL_AT_RC: begin
            if (rd_i) val_d = 32'h00000000;
            val_d = val_d | hw_set_i;
         end
         `RATL_AT_RW1C, `RATL_AT_W1C: begin
            if (wr_i) val_d = val_q & ~wdata_i;
            val_d = val_d | hw_set_i;
         end
         `RATL_AT_RW1S: begin
            if (wr_i) val_d = val_q | wdata_i;
         end
         default: val_d = 32'h00000000;
      endcase
   end
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) val_q <= RESET;
      else val_q <= val_d & MASK;
   end
   assign value_o = val_q;
   // write-only kinds read as zero; reserved bits masked to zero
   assign rdata_o = (ACCESS == `RATL_AT_WO || ACCESS == `RATL_AT_W1C || ACCESS == `RATL_AT_RSV)
                    ? 32'h00000000 : (val_q & MASK);
endmodule

// ---- ratl_bank_props.sv ----
`timescale 1ns/1ps
module ratl_bank_props #(
   parameter [31:0] BASE_ADDR = 32'h40000000,
   parameter [31:0] RSV_MASK  = 32'h00000000
) (
   input wire logic        clk_i,
   input wire logic        rst_n_i,
   input wire logic        sel_i,
   input wire logic        wr_i,
   input wire logic        ack_o,
   input wire logic        err_o,
   input wire logic [31:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic [31:0] rdata_o,
   input wire logic [31:0] ctrl_o,
   input wire logic [31:0] set_o,
   input wire logic [31:0] wo_o
);
   wire [31:0] keep = ~RSV_MASK;
   wire [31:0] ofs = addr_i - BASE_ADDR;
   wire        wa  = sel_i & wr_i;
   wire        ra  = sel_i & ~wr_i;
   wire        map = (ofs <= 32'h00000018) && (ofs[1:0] == 2'h0);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   bus_ack_a: assert property (sel_i |=> ack_o) else $error("no ack");
   idle_ack_a: assert property (!sel_i |=> !ack_o) else $error("stray ack");
   bad_map_a: assert property (sel_i && !map |=> err_o) else $error("no err");
   good_map_a: assert property (sel_i && map |=> !err_o) else $error("false err");
   err_data_a: assert property (err_o |-> rdata_o == 0) else $error("err data");
   rw_store_a: assert property (wa && ofs == 0 |=> ##1
      ctrl_o == ($past(wdata_i, 2) & keep)) else $error("rw store");
   rw_read_a: assert property (ra && ofs == 0 |=> rdata_o == ctrl_o) else $error("rw read");
   set_bits_a: assert property (wa && ofs == 16 |=> ##1
      set_o == (($past(set_o) | $past(wdata_i, 2)) & keep)) else $error("w1s");
   wo_store_a: assert property (wa && ofs == 24 |=> ##1
      wo_o == ($past(wdata_i, 2) & keep)) else $error("wo store");
   wo_read_a: assert property (ra && (ofs == 20 || ofs == 24) |=> rdata_o == 0) else $error("wo rd");
   rsv_read_a: assert property (ack_o |-> (rdata_o & RSV_MASK) == 0) else $error("rsv");
endmodule
bind ratl_bank ratl_bank_props #(.BASE_ADDR(BASE_ADDR), .RSV_MASK(RSV_MASK)) u_props (
   .clk_i(clk_i), .rst_n_i(rst_n_i),
   .sel_i(sel_i), .wr_i(wr_i), .ack_o(ack_o), .err_o(err_o), .addr_i(addr_i), .wdata_i(wdata_i),
   .rdata_o(rdata_o), .ctrl_o(ctrl_o), .set_o(set_o), .wo_o(wo_o));

// ---- ratl_host.sv ----
`timescale 1ns/1ps
module ratl_host #(parameter [31:0] BASE = 32'h40000000) (
   input  wire logic        clk_i,
   output logic             sel_o = 1'b0,
   output logic             wr_o = 1'b0,
   output logic [31:0]      addr_o = 32'h0,
   output logic [31:0]      wdata_o = 32'h0,
   input  wire logic [31:0] rdata_i
);
   // one access: request taken at the next edge, answer taken at the edge that sees ack;
   // released lines show inverted values so a late sample cannot pass
   task acc(input logic w, input logic [11:0] o, input logic [31:0] d, output logic [31:0] q);
      @(posedge clk_i);
      {sel_o, wr_o, addr_o, wdata_o} <= {1'b1, w, BASE + {20'h0, o}, d};
      @(posedge clk_i);
      {sel_o, wr_o, addr_o, wdata_o} <= {1'b0, ~wr_o, ~addr_o, ~wdata_o};
      @(posedge clk_i);
      q = rdata_i;
   endtask
endmodule

// ---- ratl_bank_test.sv ----
`timescale 1ns/1ps
`include "ratl_defs.vh"
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_total++; \
   $display("Error %0t: got %h exp %h", $time, a, b); end end
module ratl_bank_test;
   logic        clk_i = 0, rst_n_i = 0, sel, wr, ack, err;
   logic [31:0] addr, wdata, rdata, ctrl, sts, wo, w1c, q;
   logic [31:0] ro_val = 0, rc_set = 0, st_set = 0, w1c_set = 0;
   int          err_total = 0, tests_run = 0, cyc = 0;
   // top nibble reserved so that the masking is exercised
   localparam logic [31:0] RSV = 32'hf0000000;
   ratl_host u_host (.clk_i(clk_i), .sel_o(sel), .wr_o(wr), .addr_o(addr), .wdata_o(wdata),
      .rdata_i(rdata));
   ratl_bank #(.RSV_MASK(RSV)) u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .sel_i(sel), .wr_i(wr),
      .addr_i(addr), .wdata_i(wdata), .ro_val_i(ro_val), .rc_set_i(rc_set), .st_set_i(st_set),
      .w1c_set_i(w1c_set), .rdata_o(rdata), .ack_o(ack), .err_o(err), .ctrl_o(ctrl),
      .set_o(sts), .wo_o(wo), .w1c_o(w1c));
   initial forever #50 clk_i = ~clk_i;
   task close_out;
      $display("checks %0d errors %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 1000) begin
         err_total++;
         close_out;
      end
   end
   task hw(input logic [31:0] r, s, w);
      @(posedge clk_i);
      {rc_set, st_set, w1c_set} <= {r, s, w};
      @(posedge clk_i);
      {rc_set, st_set, w1c_set} <= '0;
   endtask
   task rd(input logic [11:0] o, input logic [31:0] e);
      u_host.acc(1'b0, o, 32'h0, q);
      `CHK(ack, 1'b1)
      `CHK(q, e)
   endtask
   task wrt(input logic [11:0] o, input logic [31:0] d);
      u_host.acc(1'b1, o, d, q);
      `CHK(ack, 1'b1)
   endtask
   task t_rw_ro;
      @(posedge clk_i) ro_val <= 32'h0000beef;
      wrt(`RATL_OFS_RW, 32'ha5a50f0f);
      rd(`RATL_OFS_RW, 32'ha5a50f0f & ~RSV);
      `CHK(ctrl, 32'ha5a50f0f & ~RSV)
      // read-modify-write keeps the reserved bits as read
      wrt(`RATL_OFS_RW, q | 32'h000000f0);
      rd(`RATL_OFS_RW, 32'h05a50fff);
      wrt(`RATL_OFS_RO, 32'h0);
      rd(`RATL_OFS_RO, 32'h0000beef);
   endtask
   task t_rc;
      hw(32'h11, 32'h0, 32'h0);
      rd(`RATL_OFS_RC, 32'h11);
      rd(`RATL_OFS_RC, 32'h0);
   endtask
   task t_stat;
      hw(32'h0, 32'h0f, 32'h0);
      wrt(`RATL_OFS_RW1C, 32'h0);
      rd(`RATL_OFS_RW1C, 32'h0f);
      hw(32'h0, 32'h30, 32'h0);
      wrt(`RATL_OFS_RW1C, 32'h0f);
      rd(`RATL_OFS_RW1C, 32'h30);
      hw(32'h0, 32'h0, 32'h100);
      wrt(`RATL_OFS_RW1C, 32'h30);
      // w1c_o shows a clear one edge after the field takes it
      @(posedge clk_i);
      `CHK(w1c, 32'h100)
      wrt(`RATL_OFS_W1C, 32'h100);
      rd(`RATL_OFS_W1C, 32'h0);
      `CHK(w1c, 32'h0)
   endtask
   task t_set_wo;
      wrt(`RATL_OFS_RW1S, 32'h1);
      wrt(`RATL_OFS_RW1S, 32'h2);
      wrt(`RATL_OFS_RW1S, 32'h0);
      rd(`RATL_OFS_RW1S, 32'h3);
      `CHK(sts, 32'h3)
      wrt(`RATL_OFS_WO, 32'h1234);
      rd(`RATL_OFS_WO, 32'h0);
      `CHK(wo, 32'h1234)
      u_host.acc(1'b0, 12'h01c, 32'h0, q);
      `CHK(err, 1'b1)
      `CHK(q, 32'h0)
   endtask
   task t_reset;
      @(posedge clk_i) rst_n_i <= 1'b0;
      @(posedge clk_i);
      `CHK(ctrl, `RATL_RST_RW)
      `CHK(sts, `RATL_RST_RW1S)
      repeat (2) @(posedge clk_i);
      rst_n_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      rd(`RATL_OFS_RW, `RATL_RST_RW);
      rd(`RATL_OFS_RW1S, `RATL_RST_RW1S);
   endtask
   initial begin
      repeat (3) @(posedge clk_i);
      rst_n_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      t_rw_ro;
      t_rc;
      t_stat;
      t_set_wo;
      t_reset;
      close_out;
   end
endmodule
